//--- common/sec_erase_pkg.sv
package sec_erase_pkg;
    // core clock rate and default erase time
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned ERASE_TIME_NS = 300_000;
    // opcodes
    localparam logic [7:0] OP_ERASE = 8'h44;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    // frame lengths in bits
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] ERASE_BITS = 6'h20;
    localparam logic [5:0] CNT_MAX = 6'h3f;
    localparam logic [5:0] CNT_FIRST = 6'h01;
    // address fields of a security register
    localparam logic [7:0] ADDR_TOP = 8'h00;
    localparam logic [3:0] ADDR_NIB8 = 4'h0;
    localparam logic [3:0] REG_FIRST = 4'h1;
    localparam logic [3:0] REG_LAST = 4'h3;
    // erased byte value and last byte index
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] BYTE_LAST = 8'hff;
    // reset values
    localparam logic [2:0] LOCK_RST = 3'h0;
    localparam logic [2:0] CS_SYNC_RST = 3'h7;
    // erase sequencer states, gray from idle to finish, both bits flip on return to idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_FINISH = 2'b11
    } erase_state_t;
    // one shifted frame: opcode then address
    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
    } frame_t;
    // status bits seen by the host
    typedef struct packed {
        logic write_enable_latch;
        logic busy;
    } status_t;
endpackage : sec_erase_pkg

//--- rtl/security_register_erase.sv
// How it works
// - three separate 256-byte security registers
// - erase accepted only with write_enable_latch set
// - address picks register one to three
// - wrong bit count discards the command
// - select rise starts timed erase
// - status read still served while busy
// - busy one during erase, zero after
// - erase end clears write_enable_latch
// - lock bits set once, cleared only by reset
// - locked register ignores erase, stays unchanged
// - erase refused in four_line_command_mode
// - erase leaves every byte at FFh
module security_register_erase #(
    parameter int unsigned ERASE_TIME_NS = sec_erase_pkg::ERASE_TIME_NS
) (
    // core clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_oe_o,
    // mode and lock control
    input wire logic four_line_command_mode_i,
    input wire logic [2:0] lock_set_i,
    output logic [2:0] security_lock_bits_o,
    // status
    output logic busy_o,
    output logic write_enable_latch_o,
    // array access port
    input wire logic [1:0] rd_sel_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    input wire logic prog_we_i,
    input wire logic [1:0] prog_sel_i,
    input wire logic [7:0] prog_addr_i,
    input wire logic [7:0] prog_data_i
);
    import sec_erase_pkg::*;

    // erase length in core cycles, rounded up
    localparam int unsigned ERASE_CYC = (ERASE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [31:0] ERASE_LOAD = 32'(ERASE_CYC - 1);

    // register number 1..3 from an address, 0 when none
    function automatic logic [1:0] reg_index(input logic [23:0] a);
        logic ok;
        ok = (a[23:16] == ADDR_TOP) && (a[11:8] == ADDR_NIB8)
            && (a[15:12] >= REG_FIRST) && (a[15:12] <= REG_LAST);
        return ok ? a[13:12] : 2'h0;
    endfunction : reg_index

    ////////////////////////////////////////////////////////////////////
    // link domain
    ////////////////////////////////////////////////////////////////////
    frame_t frame_q; // shift register, stable once select is high
    logic [5:0] cnt_q; // bits in current frame, saturating
    logic fr_q; // first edge of frame seen
    logic [1:0] st_s0_q; // status sync, first stage
    logic [1:0] st_s1_q; // status sync, second stage
    logic [7:0] sdo_q; // status byte being shifted out
    logic sdo_oe_q; // driving data out

    // frame start flag, cleared by select high or reset
    always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i) begin
        if (cs_n_i || rst_i) begin
            fr_q <= 1'b0;
        end else begin
            fr_q <= 1'b1;
        end
    end

    // shift in opcode and address, msb first
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_q <= '0;
            cnt_q <= '0;
        end else begin
            frame_q <= {frame_q[30:0], serial_data_in_i};
            if (!fr_q) begin
                cnt_q <= CNT_FIRST; // new frame
            end else if (cnt_q != CNT_MAX) begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    // status bits into the link clock
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_s0_q <= '0;
            st_s1_q <= '0;
        end else begin
            st_s0_q <= {write_enable_latch_o, busy_o};
            st_s1_q <= st_s0_q;
        end
    end

    // status byte out on falling edge, repeated every byte, seven bytes at most
    // only the first byte of a frame may start a status answer
    always_ff @(negedge sclk_i or posedge cs_n_i or posedge rst_i) begin
        if (cs_n_i || rst_i) begin
            sdo_q <= '0;
            sdo_oe_q <= 1'b0;
        end else if (cnt_q >= CMD_BITS && cnt_q[2:0] == 3'h0
                && (sdo_oe_q || (cnt_q == CMD_BITS && frame_q[7:0] == OP_RDSR))) begin
            sdo_q <= {6'h00, st_s1_q};
            sdo_oe_q <= 1'b1;
        end else begin
            sdo_q <= {sdo_q[6:0], 1'b0};
        end
    end

    assign serial_data_out_o = sdo_q[7];
    assign serial_data_oe_o = sdo_oe_q;

    ////////////////////////////////////////////////////////////////////
    // core domain: crossing and decode
    ////////////////////////////////////////////////////////////////////
    logic [2:0] cs_s_q; // select sync plus edge stage
    logic [1:0] quad_s_q; // mode pin sync
    logic cs_rise; // frame ended
    logic [7:0] opc; // opcode of the ended frame
    logic [1:0] tgt; // addressed register
    logic lock_hit; // target is locked
    logic erase_ok; // all erase checks pass
    erase_state_t state_q; // sequencer state

    // select edge; frame word is frozen while select is high
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_s_q <= CS_SYNC_RST;
            quad_s_q <= '0;
        end else begin
            cs_s_q <= {cs_s_q[1:0], cs_n_i};
            quad_s_q <= {quad_s_q[0], four_line_command_mode_i};
        end
    end

    // decode of the finished frame
    always_comb begin
        cs_rise = cs_s_q[1] & ~cs_s_q[2];
        opc = (cnt_q == CMD_BITS) ? frame_q[7:0] : frame_q.opcode;
        tgt = reg_index(frame_q.addr);
        lock_hit = (tgt != 2'h0) && security_lock_bits_o[tgt - 2'h1];
        erase_ok = cs_rise && (state_q == ST_IDLE)
            && (cnt_q == ERASE_BITS)
            && (frame_q.opcode == OP_ERASE)
            && write_enable_latch_o
            && !quad_s_q[1]
            && (tgt != 2'h0)
            && !lock_hit;
    end

    ////////////////////////////////////////////////////////////////////
    // core domain: erase sequencer
    ////////////////////////////////////////////////////////////////////
    logic [31:0] timer_q; // cycles left of the erase
    logic [1:0] sel_q; // register being erased
    logic [7:0] ptr_q; // wipe pointer
    logic wipe_q; // wipe still running
    logic [7:0] mem_q [1:3][0:255];

    // state, timer and busy flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            timer_q <= '0;
            sel_q <= '0;
            busy_o <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (erase_ok) begin
                        state_q <= ST_ERASE;
                        timer_q <= ERASE_LOAD;
                        sel_q <= tgt;
                        busy_o <= 1'b1;
                    end
                end
                ST_ERASE: begin
                    if (timer_q == '0) begin
                        state_q <= ST_FINISH;
                    end else begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
                ST_FINISH: begin
                    state_q <= ST_IDLE;
                    busy_o <= 1'b0;
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_o <= 1'b0;
                end
            endcase
        end
    end

    // write enable latch
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            write_enable_latch_o <= 1'b0;
        end else if (state_q == ST_FINISH) begin
            write_enable_latch_o <= 1'b0;
        end else if (cs_rise && state_q == ST_IDLE && cnt_q == CMD_BITS) begin
            if (opc == OP_WREN) begin
                write_enable_latch_o <= 1'b1;
            end else if (opc == OP_WRDI) begin
                write_enable_latch_o <= 1'b0;
            end
        end
    end

    // lock bits gain ones and lose them only at reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            security_lock_bits_o <= LOCK_RST;
        end else begin
            security_lock_bits_o <= security_lock_bits_o | lock_set_i;
        end
    end

    // wipe pointer walks all bytes once per erase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_q <= '0;
            wipe_q <= 1'b0;
        end else if (erase_ok) begin
            ptr_q <= '0;
            wipe_q <= 1'b1;
        end else if (wipe_q) begin
            ptr_q <= ptr_q + 8'h01;
            wipe_q <= (ptr_q != BYTE_LAST);
        end
    end

    // array writes: wipe first, else program port
    always_ff @(posedge clk_i) begin
        if (wipe_q) begin
            mem_q[sel_q][ptr_q] <= ERASED;
        end else if (prog_we_i && !busy_o && prog_sel_i != 2'h0
                && !security_lock_bits_o[prog_sel_i - 2'h1]) begin
            mem_q[prog_sel_i][prog_addr_i] <= prog_data_i;
        end
    end

    // registered read, unmapped reads as erased
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= ERASED;
        end else if (rd_sel_i == 2'h0) begin
            rd_data_o <= ERASED;
        end else begin
            rd_data_o <= mem_q[rd_sel_i][rd_addr_i];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////
    logic [31:0] bcnt_q; // cycles busy has been high

    // busy length counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bcnt_q <= '0;
        end else if (busy_o) begin
            bcnt_q <= bcnt_q + 32'h1;
        end else begin
            bcnt_q <= '0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_erase_start: assert property (erase_ok |=> busy_o && state_q == ST_ERASE)
        else $error("valid erase did not start");
    a_lock_guard: assert property (cs_rise && state_q == ST_IDLE && lock_hit |=> !busy_o)
        else $error("erase of locked register started");
    a_wel_needed: assert property (cs_rise && !write_enable_latch_o && !busy_o |=> !busy_o)
        else $error("erase started without write enable");
    a_bit_count: assert property (cs_rise && cnt_q != ERASE_BITS && !busy_o |=> !busy_o)
        else $error("erase started on wrong frame length");
    a_quad_refuse: assert property (cs_rise && quad_s_q[1] && !busy_o |=> !busy_o)
        else $error("erase started in four line mode");
    a_busy_length: assert property ($fell(busy_o) |-> bcnt_q == 32'(ERASE_CYC + 1))
        else $error("busy length differs from erase time");
    a_wel_clear: assert property (state_q == ST_FINISH |=> !write_enable_latch_o && !busy_o)
        else $error("latch or busy not cleared at end");
    a_wipe_ff: assert property (wipe_q |=> mem_q[$past(sel_q)][$past(ptr_q)] == ERASED)
        else $error("erased byte not FFh");
    a_busy_ignore: assert property (state_q == ST_ERASE && timer_q != '0
            |=> $stable(write_enable_latch_o) && $stable(sel_q))
        else $error("command acted on while busy");
    a_lock_sticky: assert property ((security_lock_bits_o & $past(security_lock_bits_o))
            == $past(security_lock_bits_o))
        else $error("lock bit cleared");
endmodule : security_register_erase

//--- verification/serial_host.sv
// host model: drives the serial link, link clock only inside frames
module serial_host (
    // link towards the device
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // shift n bits msb first from the top of v, 30 ns link period
    task automatic shift(input logic [39:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            sdi_o = v[39 - i];
            #15 sclk_o = 1'b1;
            #15 sclk_o = 1'b0;
        end
    endtask : shift
    // whole frame; select rises after the last latched bit
    task automatic frame(input logic [39:0] v, input int n);
        cs_n_o = 1'b0;
        shift(v, n);
        #15 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #300;
    endtask : frame
    // status read: second byte kept, first may lag
    task automatic status(output logic [7:0] s);
        cs_n_o = 1'b0;
        shift({sec_erase_pkg::OP_RDSR, 32'h0}, 8);
        for (int i = 0; i < 16; i++) begin
            sdi_o = i[0];
            #15 sclk_o = 1'b1;
            s = {s[6:0], sdo_i};
            #15 sclk_o = 1'b0;
        end
        #15 cs_n_o = 1'b1;
        #300;
    endtask : status
endmodule : serial_host

//--- verification/testbench.sv
// self-checking bench for the security register erase block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sec_erase_pkg::*;
    localparam int unsigned T_NS = 13000; // short erase time
    localparam int ERASE_CYC = T_NS / 50;
    logic clk_i = 1'b0, rst_i, mode_i = 1'b0, prog_we_i = 1'b0;
    logic [2:0] lock_set_i = 3'h0, lock_bits, lk = 3'h0;
    logic [1:0] rd_sel_i = 2'h0, prog_sel_i = 2'h0;
    logic [7:0] rd_addr_i = 8'h00, prog_addr_i = 8'h00, prog_data_i = 8'h00, rd_data, st;
    logic sclk, cs_n, sdi, sdo, busy_o, write_enable_latch, oe;
    int errors = 0, compares = 0, busy_cnt = 0, busy_len = 0, oe_cnt = 0;
    always #25 clk_i = ~clk_i;
    serial_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
    security_register_erase #(.ERASE_TIME_NS(T_NS)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .serial_data_in_i(sdi),
        .serial_data_out_o(sdo), .serial_data_oe_o(oe), .four_line_command_mode_i(mode_i),
        .lock_set_i(lock_set_i), .security_lock_bits_o(lock_bits), .busy_o(busy_o),
        .write_enable_latch_o(write_enable_latch), .rd_sel_i(rd_sel_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data),
        .prog_we_i(prog_we_i), .prog_sel_i(prog_sel_i), .prog_addr_i(prog_addr_i),
        .prog_data_i(prog_data_i));
    // length of the last busy stretch in core cycles
    always @(posedge clk_i) begin
        if (busy_o === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
        end else if (busy_cnt != 0) begin
            busy_len <= busy_cnt;
            busy_cnt <= 0;
        end
    end
    // link clock rises seen while the device drives data out
    always @(posedge sclk) begin
        if (oe === 1'b1) begin
            oe_cnt <= oe_cnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        if (errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // read one byte of a register through the test port
    task automatic rd(input logic [1:0] sel, output logic [7:0] d);
        @(negedge clk_i) rd_sel_i = sel;
        rd_addr_i = 8'h10;
        @(negedge clk_i) d = rd_data;
    endtask : rd
    // wait a bounded span for busy to reach a level
    task automatic wait_busy(input logic lvl, input int lim);
        for (int i = 0; i < lim && busy_o !== lvl; i++) begin
            @(negedge clk_i);
        end
    endtask : wait_busy
    ////////////////////////////////////////////////////////////////
    // one erase attempt on a freshly written byte, go says if it must run
    task automatic try_erase(input logic [1:0] sel, input logic [39:0] v, input int n,
                             input logic wren, input logic go);
        logic [7:0] d;
        logic [7:0] want;
        int o;
        want = (lk[sel - 2'h1] === 1'b1) ? ERASED : 8'h3c;
        o = oe_cnt;
        @(negedge clk_i) prog_sel_i = sel;
        prog_addr_i = 8'h10;
        prog_data_i = 8'h3c;
        prog_we_i = 1'b1;
        @(negedge clk_i) prog_we_i = 1'b0;
        rd(sel, d);
        check("byte before", d, want);
        if (wren) begin
            i_host.frame({OP_WREN, 32'h0}, 8);
        end
        i_host.frame(v, n);
        wait_busy(1'b1, 10);
        check("busy start", busy_o, go);
        if (go) begin
            i_host.frame({OP_WRDI, 32'h0}, 8);
            i_host.status(st);
            check("status busy", st, 8'h03);
            check("drive end", oe, 1'b0);
            wait_busy(1'b0, 300);
            @(negedge clk_i);
            check("busy length", busy_len, ERASE_CYC + 1);
            check("latch after", write_enable_latch, 1'b0);
            i_host.status(st);
            check("status idle", st, 8'h00);
        end else begin
            check("latch kept", write_enable_latch, wren);
        end
        check("drive count", oe_cnt - o, go ? 32 : 0);
        rd(sel, d);
        check("byte after", d, go ? ERASED : want);
    endtask : try_erase
    ////////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        errors++;
        give_verdict();
    end
    initial begin
        logic [7:0] d;
        #1 rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        check("reset", {busy_o, write_enable_latch, lock_bits}, 5'h00);
        check("reset drive", oe, 1'b0);
        rd(2'h0, d);
        check("empty read", d, 8'hff);
        try_erase(2'h1, {OP_ERASE, 24'h001000, 8'h0}, 32, 1'b0, 1'b0);
        for (int r = 1; r <= 3; r++) begin
            try_erase(r[1:0], {OP_ERASE, 8'h00, 2'b00, r[1:0], 12'h0a5, 8'h0}, 32, 1'b1, 1'b1);
        end
        try_erase(2'h1, {OP_ERASE, 24'h001000, 8'h0}, 33, 1'b1, 1'b0);
        i_host.frame({OP_WRDI, 32'h0}, 8);
        try_erase(2'h1, {OP_ERASE, 24'h001000, 8'h0}, 31, 1'b1, 1'b0);
        try_erase(2'h1, {OP_ERASE, 24'h011000, 8'h0}, 32, 1'b1, 1'b0);
        try_erase(2'h1, {OP_ERASE, 24'h001100, 8'h0}, 32, 1'b1, 1'b0);
        try_erase(2'h1, {OP_ERASE, 24'h004000, 8'h0}, 32, 1'b1, 1'b0);
        mode_i = 1'b1;
        try_erase(2'h1, {OP_ERASE, 24'h001000, 8'h0}, 32, 1'b1, 1'b0);
        mode_i = 1'b0;
        i_host.frame({OP_WRDI, 32'h0}, 8);
        @(negedge clk_i) lock_set_i = 3'h2;
        lk = 3'h2;
        @(negedge clk_i) lock_set_i = 3'h0;
        repeat (2) @(negedge clk_i);
        check("lock set", lock_bits, 3'h2);
        try_erase(2'h2, {OP_ERASE, 24'h002000, 8'h0}, 32, 1'b1, 1'b0);
        check("lock held", lock_bits, 3'h2);
        i_host.frame({OP_WRDI, 32'h0}, 8);
        try_erase(2'h3, {OP_ERASE, 24'h003000, 8'h0}, 32, 1'b1, 1'b1);
        give_verdict();
    end
endmodule : testbench
